// File: bench/cipl_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cipl_mcu_model (
  input  wire logic       clock,                  // Bus clock
  output var  logic       register_block_select,  // Register block select
  output var  logic [7:0] mcu_addr,               // Register offset
  output var  logic       mcu_wr,                 // Write strobe
  output var  logic       mcu_rd,                 // Read strobe
  output var  logic [7:0] mcu_wdata               // Write data
);
  initial begin
    register_block_select = 1'b0;
    mcu_addr = 8'hff;
    mcu_wr = 1'b0;
    mcu_rd = 1'b0;
    mcu_wdata = 8'h00;
  end

  // One strobe cycle; address and data turn over once the access is taken
  task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    register_block_select <= 1'b1;
    mcu_addr <= a;
    mcu_wdata <= v;
    mcu_wr <= w;
    mcu_rd <= !w;
    @(posedge clock);
    register_block_select <= 1'b0;
    mcu_wr <= 1'b0;
    mcu_rd <= 1'b0;
    mcu_addr <= ~a;
    mcu_wdata <= ~v;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cycle(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    cycle(1'b0, a, 8'h00);
  endtask
endmodule // cipl_mcu_model
`default_nettype wire

// File: bench/cipl_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cipl_port_chk (
  input wire logic       clock,                  // System clock
  input wire logic       rst,                    // Async reset, high
  input wire logic       register_block_select,  // Register block select
  input wire logic [7:0] mcu_addr,               // Register offset
  input wire logic       mcu_wr,                 // Write strobe
  input wire logic       mcu_rd,                 // Read strobe
  input wire logic [7:0] mcu_wdata,              // Write data
  input wire logic [7:0] mcu_rdata,              // Read data
  input wire logic [2:0] oe_term_d,              // Port D enable terms
  input wire logic [2:0] pd_oe,                  // Port D enables
  input wire logic [2:0] pd_in,                  // Port D pins
  input wire logic [7:0] pc_in,                  // Port C pins
  input wire logic [3:0] pa_fast_slew,           // Port A slew bits
  input wire logic [2:0] pd_fast_slew,           // Port D slew bits
  input wire logic       memory_disable,         // Chip select input high
  input wire logic [2:0] logic_in_d,             // Port D to the logic
  input wire logic [7:0] jtag_in                 // Port C to the test port
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire take_wr = register_block_select && !memory_disable && mcu_wr && mcu_addr[7:6] == 2'h0;

  chk_rd_unmapped: assert property (mcu_rd && mcu_addr[7:6] != 2'h0 |=> mcu_rdata == 8'h00)
    else $error("unmapped read returned data");
  chk_rd_deselected: assert property (mcu_rd && memory_disable |=> mcu_rdata == 8'h00)
    else $error("read while disabled returned data");
  chk_rdata_hold: assert property (!mcu_rd |=> $stable(mcu_rdata))
    else $error("read data moved without a read");
  chk_slew_write: assert property (take_wr && mcu_addr == 8'h10 |=> pa_fast_slew == $past(mcu_wdata[3:0]))
    else $error("port A slew bits not loaded");
  chk_slew_only_write: assert property (!$stable(pa_fast_slew) |-> $past(take_wr && mcu_addr == 8'h10))
    else $error("port A slew bits moved without a write");
  chk_slew_d_write: assert property (take_wr && mcu_addr == 8'h13 |=> pd_fast_slew == $past(mcu_wdata[2:0]))
    else $error("port D slew bits not loaded");
  chk_oe_term_d: assert property ((oe_term_d[1:0] & ~pd_oe[1:0]) == 2'h0)
    else $error("port D enable term did not drive pin");
  chk_csi_source: assert property (memory_disable |-> $past(pd_in[2], 2))
    else $error("disable without chip select input high");
  chk_jtag_view: assert property (jtag_in == $past(pc_in, 2))
    else $error("test port view differs from port C pins");
  chk_logic_in_d: assert property (logic_in_d == $past(pd_in, 2))
    else $error("port D logic input differs from pins");

  cov_write: cover property (take_wr);
  cov_read_disabled: cover property (mcu_rd && memory_disable);
  cov_disable_rise: cover property ($rose(memory_disable));
endmodule // cipl_port_chk

bind cipl_port cipl_port_chk i_chk (
  .clock, .rst, .register_block_select, .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata,
  .mcu_rdata, .oe_term_d, .pd_oe, .pd_in, .pc_in, .pa_fast_slew, .pd_fast_slew,
  .memory_disable, .logic_in_d, .jtag_in
);
`default_nettype wire

// File: bench/tb_cipl_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cipl_port;
  logic       clock, rst, register_block_select, mcu_wr, mcu_rd, rd_seen;
  logic       data_bus_oe, periph_select, jtag_enable, memory_disable;
  logic [7:0] mcu_addr, mcu_wdata, mcu_rdata, data_bus_out, addr_out_a, addr_out_b;
  logic [7:0] oe_term_a, oe_term_b, oe_term_c, cell_d_one, cell_d_two, jtag_out;
  logic [7:0] jtag_oe, pa_ext, pb_in, pc_in, pa_out, pa_oe, pc_out, pc_oe, og_one, d, p;
  logic [3:0] pa_fast_slew;
  logic [2:0] oe_term_d, select_terms, pd_in, pd_fast_slew, pd_out, pd_oe;
  wire  [7:0] pa_in;
  logic [7:0] exp_q[$];
  int         n_fail, comparisons, seed;

  // Port A wire level: design wins where it drives
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);

  cipl_mcu_model i_mcu (.clock, .register_block_select, .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata);

  cipl_port i_dut (
    .clock, .rst, .register_block_select, .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata,
    .mcu_rdata, .data_bus_out, .data_bus_oe, .data_bus_in(), .periph_select,
    .addr_out_a, .addr_out_b, .oe_term_a, .oe_term_b, .oe_term_c, .oe_term_d,
    .cell_d_one, .cell_d_two, .output_cell_group_one(og_one), .output_cell_group_two(),
    .select_terms, .ilc_out_a(), .ilc_out_b(), .ilc_out_c(), .logic_in_d(),
    .address_strobe_input(), .logic_clock_input(), .memory_disable,
    .data_byte_enable_input(), .jtag_enable, .jtag_out, .jtag_oe, .jtag_in(),
    .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out(), .pb_oe(), .pc_in, .pc_out, .pc_oe,
    .pd_in, .pd_out, .pd_oe, .pa_fast_slew, .pb_fast_slew(), .pd_fast_slew
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_mcu.rd(a);
  endtask

  task automatic settle();
    @(negedge clock);
  endtask

  // Read data shows one cycle after the strobe is taken
  always @(posedge clock) begin
    if (rd_seen && exp_q.size() != 0)
      check8("mcu_rdata", exp_q.pop_front(), mcu_rdata);
    rd_seen <= mcu_rd;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("[ERR] run end expected reached seen hung");
    complete_run();
  end

  initial begin
    seed = 32'h3c8d5e57;
    rst = 1'b1;
    {data_bus_oe, periph_select, jtag_enable, addr_out_a, oe_term_a, oe_term_c} = '0;
    {pa_ext, pb_in, pc_in, pd_in, oe_term_d} = '0;
    data_bus_out = rnd8();
    addr_out_b = rnd8();
    oe_term_b = rnd8();
    cell_d_one = rnd8();
    cell_d_two = rnd8();
    jtag_out = rnd8();
    jtag_oe = rnd8();
    select_terms = 3'(rnd8());
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(8'h18, 8'h00);
    rd(8'h10, 8'h00);
    d = rnd8();
    @(posedge clock);
    pa_ext <= ~d;
    pb_in <= rnd8();
    pc_in <= rnd8();
    oe_term_d <= 3'h1;
    i_mcu.wr(8'h08, d);
    rd(8'h08, d);
    settle();
    check8("pa_oe", 8'h00, pa_oe);
    @(posedge clock);
    oe_term_a <= 8'h0f;
    settle();
    check8("pa_oe", 8'h0f, pa_oe);
    check8("pa_out", d & 8'h0f, pa_out & 8'h0f);
    i_mcu.wr(8'h0c, 8'hc0);
    settle();
    check8("pa_oe", 8'hcf, pa_oe);
    rd(8'h20, 8'hcf);
    p = rnd8();
    @(posedge clock);
    pa_ext <= p;
    repeat (3) @(posedge clock);
    rd(8'h00, (d & 8'hcf) | (p & 8'h30));
    i_mcu.wr(8'h18, 8'h0f);
    i_mcu.wr(8'h14, 8'hff);
    rd(8'h14, 8'hf0);
    rd(8'h18, 8'h0f);
    check8("output_cell_group_one", 8'hf0, og_one);
    i_mcu.wr(8'h0c, 8'hff);
    i_mcu.wr(8'h10, 8'hf3);
    settle();
    check8("pa_fast_slew", 8'h03, {4'h0, pa_fast_slew});
    check8("pa_oe drain", {~d[7:4], 4'hf}, pa_oe);
    check8("pa_out drain", {4'h0, d[3:0]}, pa_out);
    i_mcu.wr(8'h0e, 8'hff);
    i_mcu.wr(8'h0a, 8'h3c);
    i_mcu.wr(8'h12, 8'hff);
    settle();
    check8("pc_oe", 8'hc3, pc_oe);
    check8("pc_out", 8'h00, pc_out);
    i_mcu.wr(8'h13, 8'hff);
    rd(8'h13, 8'h07);
    i_mcu.wr(8'h06, 8'hff);
    rd(8'h06, 8'h00);
    d = rnd8();
    @(posedge clock);
    addr_out_a <= d;
    i_mcu.wr(8'h10, 8'h00);
    i_mcu.wr(8'h04, 8'hff);
    settle();
    check8("pa_out address", d, pa_out);
    rd(8'h04, 8'hff);
    rd(8'h40, 8'h00);
    @(posedge clock);
    data_bus_oe <= 1'b1;
    pd_in <= 3'h1;
    i_mcu.wr(8'h27, 8'h07);
    i_mcu.wr(8'h29, 8'h05);
    i_mcu.wr(8'h0f, 8'h07);
    i_mcu.wr(8'h28, 8'h11);
    settle();
    // Selects 0 and 2 active high, select 1 active low
    check8("pd_out", {5'h00, select_terms ^ 3'h2}, {5'h00, pd_out});
    check8("pd_oe", 8'h07, {5'h00, pd_oe});
    check8("pa_out data port", data_bus_out, pa_out);
    check8("pc_oe byte enable", 8'h43, pc_oe);
    rd(8'h1e, pc_in);
    i_mcu.wr(8'h28, 8'h20);
    @(posedge clock);
    pd_in <= 3'h4;
    repeat (3) @(posedge clock);
    settle();
    check8("memory_disable", 8'h01, {7'h0, memory_disable});
    check8("pd_oe chip select", 8'h03, {5'h00, pd_oe});
    rd(8'h08, 8'h00);
    for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(posedge clock);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("[ERR] read queue expected 0 seen %0d", exp_q.size());
    end
    complete_run();
  end
endmodule // tb_cipl_port
`default_nettype wire

// File: rtl/cipl_map.vh
`ifndef CIPL_MAP_VH
`define CIPL_MAP_VH

// Register address = {2'b00, type[3:0], port[1:0]}
`define CIPL_TYPE_PIN_INPUT_SAMPLE   4'h0
`define CIPL_TYPE_MODE_CONTROL       4'h1
`define CIPL_TYPE_PIN_OUTPUT_LATCH   4'h2
`define CIPL_TYPE_DIRECTION          4'h3
`define CIPL_TYPE_PAD_DRIVE_SELECT   4'h4
`define CIPL_TYPE_LOGIC_CELL_OUTPUT  4'h5
`define CIPL_TYPE_LOGIC_CELL_BLOCK   4'h6
`define CIPL_TYPE_INPUT_LATCH_CELL   4'h7
`define CIPL_TYPE_DRIVER_ENABLE_VIEW 4'h8
`define CIPL_TYPE_CELL_SELECT        4'h9
`define CIPL_TYPE_PORT_FUNCTION      4'ha

`define CIPL_PORT_A 2'h0
`define CIPL_PORT_B 2'h1
`define CIPL_PORT_C 2'h2
`define CIPL_PORT_D 2'h3

// Fields of the port function register, port A slot
`define CIPL_FN_DATA_PORT   0
`define CIPL_FN_PERIPH      1
`define CIPL_FN_ONE_TO_B    2
`define CIPL_FN_TWO_TO_C    3
`define CIPL_FN_DBE_EN      4
`define CIPL_FN_CSI_EN      5
`define CIPL_FN_ILC_BY_CLK  6

// Drive select layout
`define CIPL_DRV_OD_HI   7
`define CIPL_DRV_OD_LO   4
`define CIPL_DRV_SLEW_HI 3
`define CIPL_DRV_SLEW_LO 0
`define CIPL_D_PINS      3

`define CIPL_RESET_BYTE 8'h00
`define CIPL_UNMAPPED   8'h00

`endif

// File: rtl/cipl_pad.v
`timescale 1ns/1ps
`default_nettype none

module cipl_pad #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] value,   // Level to present
  input  wire [WIDTH-1:0] enable,  // Driver in output mode
  input  wire [WIDTH-1:0] od_sel,  // Open drain select
  output wire [WIDTH-1:0] pin_out, // Pin output level
  output wire [WIDTH-1:0] pin_oe   // High while the pin is driven
);

  // Open drain only pulls low; a high is left to the pull-up
  assign pin_out = value & ~od_sel;
  assign pin_oe  = enable & (~od_sel | ~value);

endmodule // cipl_pad

`default_nettype wire

// File: rtl/cipl_port.v
`timescale 1ns/1ps
`default_nettype none
`include "cipl_map.vh"

// Summary of operation
// - Pin outputs when direction or enable term set
// - Output latch drives pin when enabled
// - Pin input view returns live pin level
// - Output latch stores writes, reads back latch
// - Cell location reads outputs, writes unblocked flops
// - Block bit set stops MCU loading, logic clock still loads; resets unblocked
// - Enable view shows one when driver active
// - Input latch cells capture pins, feed logic, readable
// - Ports A,B: high nibble drain, low slew
// - Port C drive bits all open drain
// - Port D only three slew bits exist
// - Cell groups routed A/B and B/C
// - Port A usable as non-multiplexed data bus
// - Peripheral buffer mode on port A only
// - Ports C,D lack address out and control
// - Port D inputs feed logic directly
// - Port D dedicated strobe, clock, chip select inputs
// - External selects: one term, polarity, enable
// - Port C may be taken by test port
// - Port C top pin as byte enable input
// - Control bit zero GPIO, one address out
module cipl_port (
  input  wire       clock,             // 40 MHz system clock
  input  wire       rst,               // Async reset, high
  input  wire       register_block_select, // Register block select from decoder
  input  wire [7:0] mcu_addr,          // Register offset
  input  wire       mcu_wr,            // Write strobe, one cycle
  input  wire       mcu_rd,            // Read strobe, one cycle
  input  wire [7:0] mcu_wdata,         // Write data
  output reg  [7:0] mcu_rdata,         // Read data, valid cycle after mcu_rd
  input  wire [7:0] data_bus_out,      // Device data for port A data bus mode
  input  wire       data_bus_oe,       // Device drives port A data bus
  output wire [7:0] data_bus_in,       // MCU data seen on port A
  input  wire       periph_select,     // Peripheral select term
  input  wire [7:0] addr_out_a,        // Latched address for port A
  input  wire [7:0] addr_out_b,        // Latched address for port B
  input  wire [7:0] oe_term_a,         // Output enable terms port A
  input  wire [7:0] oe_term_b,         // Output enable terms port B
  input  wire [7:0] oe_term_c,         // Output enable terms port C
  input  wire [2:0] oe_term_d,         // Output enable terms port D
  input  wire [7:0] cell_d_one,        // Logic next value, group one
  input  wire [7:0] cell_d_two,        // Logic next value, group two
  output reg  [7:0] output_cell_group_one, // Logic output cells, group one
  output reg  [7:0] output_cell_group_two, // Logic output cells, group two
  input  wire [2:0] select_terms,      // Product terms of the external selects
  output wire [7:0] ilc_out_a,         // Input latch stage, port A
  output wire [7:0] ilc_out_b,         // Input latch stage, port B
  output wire [7:0] ilc_out_c,         // Input latch stage, port C
  output wire [2:0] logic_in_d,        // Port D pins straight to the logic
  output wire       address_strobe_input, // Dedicated strobe, synchronised
  output wire       logic_clock_input, // Dedicated logic clock, synchronised
  output wire       memory_disable,    // Chip select input high
  output wire       data_byte_enable_input, // Byte enable from port C top pin
  input  wire       jtag_enable,       // Test port owns port C
  input  wire [7:0] jtag_out,          // Test port pin levels
  input  wire [7:0] jtag_oe,           // Test port pin enables
  output wire [7:0] jtag_in,           // Port C levels to the test port
  input  wire [7:0] pa_in,             // Port A pins
  output wire [7:0] pa_out,            // Port A output level
  output wire [7:0] pa_oe,             // Port A output enable
  input  wire [7:0] pb_in,             // Port B pins
  output wire [7:0] pb_out,            // Port B output level
  output wire [7:0] pb_oe,             // Port B output enable
  input  wire [7:0] pc_in,             // Port C pins
  output wire [7:0] pc_out,            // Port C output level
  output wire [7:0] pc_oe,             // Port C output enable
  input  wire [2:0] pd_in,             // Port D pins
  output wire [2:0] pd_out,            // Port D output level
  output wire [2:0] pd_oe,             // Port D output enable
  output wire [3:0] pa_fast_slew,      // Port A low nibble fast slew
  output wire [3:0] pb_fast_slew,      // Port B low nibble fast slew
  output wire [2:0] pd_fast_slew       // Port D fast slew
);

  reg  [7:0] ctrl_ff  [0:1];
  reg  [7:0] dout_ff  [0:3];
  reg  [7:0] dir_ff   [0:3];
  reg  [7:0] drv_ff   [0:3];
  reg  [7:0] csel_ff  [0:3];
  reg  [7:0] func_ff;
  reg  [2:0] ecs_pol_ff;
  reg  [7:0] blk_one_ff;
  reg  [7:0] blk_two_ff;
  reg  [7:0] ilc_a_ff;
  reg  [7:0] ilc_b_ff;
  reg  [7:0] ilc_c_ff;
  reg        strobe_d_ff;
  reg        lclk_d_ff;
  reg  [7:0] nxt_rdata;
  integer    i;
  integer    j;

  wire [7:0] sa;
  wire [7:0] sb;
  wire [7:0] sc;
  wire [2:0] sd;

  cipl_sync #(.WIDTH(8)) u_sync_a (.clock(clock), .rst(rst), .async_in(pa_in), .sync_out(sa));
  cipl_sync #(.WIDTH(8)) u_sync_b (.clock(clock), .rst(rst), .async_in(pb_in), .sync_out(sb));
  cipl_sync #(.WIDTH(8)) u_sync_c (.clock(clock), .rst(rst), .async_in(pc_in), .sync_out(sc));
  cipl_sync #(.WIDTH(3)) u_sync_d (.clock(clock), .rst(rst), .async_in(pd_in), .sync_out(sd));

  wire data_port = func_ff[`CIPL_FN_DATA_PORT];
  wire periph    = func_ff[`CIPL_FN_PERIPH];
  wire one_to_b  = func_ff[`CIPL_FN_ONE_TO_B];
  wire two_to_c  = func_ff[`CIPL_FN_TWO_TO_C];
  wire dbe_en    = func_ff[`CIPL_FN_DBE_EN];
  wire csi_en    = func_ff[`CIPL_FN_CSI_EN];
  wire ilc_clk   = func_ff[`CIPL_FN_ILC_BY_CLK];

  // Dedicated port D inputs
  assign address_strobe_input = sd[0];
  assign logic_clock_input    = sd[1];
  assign memory_disable       = csi_en & sd[2];
  assign logic_in_d           = sd;

  wire strobe_rise = address_strobe_input & ~strobe_d_ff;
  wire lclk_rise   = logic_clock_input & ~lclk_d_ff;

  // Chip select input high locks out the register block
  wire acc    = register_block_select & ~memory_disable;
  wire [3:0] rtype = mcu_addr[5:2];
  wire [1:0] rport = mcu_addr[1:0];
  wire mapped = (mcu_addr[7:6] == 2'h0);
  wire wr_en  = acc & mcu_wr & mapped;
  wire rd_en  = acc & mcu_rd & mapped;
  wire wr_one = wr_en & (rtype == `CIPL_TYPE_LOGIC_CELL_OUTPUT) & (rport == `CIPL_PORT_A);
  wire wr_two = wr_en & (rtype == `CIPL_TYPE_LOGIC_CELL_OUTPUT) &
                ((rport == `CIPL_PORT_B) | (rport == `CIPL_PORT_C));
  wire [7:0] wdata_fit = (rport == `CIPL_PORT_D) ? {5'h00, mcu_wdata[2:0]} : mcu_wdata;

  // Configuration and data registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        dout_ff[i] <= `CIPL_RESET_BYTE;
        dir_ff[i]  <= `CIPL_RESET_BYTE;
        drv_ff[i]  <= `CIPL_RESET_BYTE;
        csel_ff[i] <= `CIPL_RESET_BYTE;
      end
      ctrl_ff[0] <= `CIPL_RESET_BYTE;
      ctrl_ff[1] <= `CIPL_RESET_BYTE;
      func_ff    <= `CIPL_RESET_BYTE;
      ecs_pol_ff <= 3'h0;
      blk_one_ff <= `CIPL_RESET_BYTE;
      blk_two_ff <= `CIPL_RESET_BYTE;
    end else if (wr_en) begin
      case (rtype)
        `CIPL_TYPE_MODE_CONTROL: begin
          if (rport == `CIPL_PORT_A || rport == `CIPL_PORT_B) begin
            ctrl_ff[rport[0]] <= mcu_wdata;
          end
        end
        `CIPL_TYPE_PIN_OUTPUT_LATCH: dout_ff[rport] <= mcu_wdata;
        `CIPL_TYPE_DIRECTION:        dir_ff[rport]  <= wdata_fit;
        `CIPL_TYPE_PAD_DRIVE_SELECT: drv_ff[rport]  <= wdata_fit;
        `CIPL_TYPE_LOGIC_CELL_BLOCK: begin
          if (rport == `CIPL_PORT_A) begin
            blk_one_ff <= mcu_wdata;
          end else if (rport != `CIPL_PORT_D) begin
            blk_two_ff <= mcu_wdata;
          end
        end
        `CIPL_TYPE_CELL_SELECT:      csel_ff[rport] <= mcu_wdata;
        `CIPL_TYPE_PORT_FUNCTION: begin
          if (rport == `CIPL_PORT_A) begin
            func_ff <= mcu_wdata;
          end else if (rport == `CIPL_PORT_B) begin
            ecs_pol_ff <= mcu_wdata[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Logic output cells: MCU load unless blocked, else logic clock edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      output_cell_group_one <= 8'h00;
      output_cell_group_two <= 8'h00;
      strobe_d_ff           <= 1'b0;
      lclk_d_ff             <= 1'b0;
    end else begin
      strobe_d_ff <= address_strobe_input;
      lclk_d_ff   <= logic_clock_input;
      for (j = 0; j < 8; j = j + 1) begin
        if (wr_one && !blk_one_ff[j]) begin
          output_cell_group_one[j] <= mcu_wdata[j];
        end else if (lclk_rise) begin
          output_cell_group_one[j] <= cell_d_one[j];
        end
        if (wr_two && !blk_two_ff[j]) begin
          output_cell_group_two[j] <= mcu_wdata[j];
        end else if (lclk_rise) begin
          output_cell_group_two[j] <= cell_d_two[j];
        end
      end
    end
  end

  // Input latch cells capture on the strobe or the logic clock
  wire ilc_load = ilc_clk ? lclk_rise : strobe_rise;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ilc_a_ff <= 8'h00;
      ilc_b_ff <= 8'h00;
      ilc_c_ff <= 8'h00;
    end else if (ilc_load) begin
      ilc_a_ff <= sa;
      ilc_b_ff <= sb;
      ilc_c_ff <= sc;
    end
  end

  assign ilc_out_a = ilc_a_ff;
  assign ilc_out_b = ilc_b_ff;
  assign ilc_out_c = ilc_c_ff;

  // Port A pin function
  wire [7:0] a_cell = one_to_b ? 8'h00 : csel_ff[0];
  wire [7:0] a_gpio = (ctrl_ff[0] & addr_out_a) |
                      (~ctrl_ff[0] & a_cell & output_cell_group_one) |
                      (~ctrl_ff[0] & ~a_cell & dout_ff[0]);
  wire [7:0] a_val  = data_port ? data_bus_out :
                      periph ? mcu_wdata : a_gpio;
  wire [7:0] a_en   = data_port ? {8{data_bus_oe}} :
                      periph ? {8{periph_select & mcu_wr}} :
                      (dir_ff[0] | oe_term_a);
  assign data_bus_in = sa;

  // Port B pin function
  wire [7:0] b_one  = one_to_b ? csel_ff[1] : 8'h00;
  wire [7:0] b_two  = (!one_to_b && !two_to_c) ? csel_ff[1] : 8'h00;
  wire [7:0] b_gpio = (b_one & output_cell_group_one) | (b_two & output_cell_group_two) |
                      (~b_one & ~b_two & dout_ff[1]);
  wire [7:0] b_val  = (ctrl_ff[1] & addr_out_b) | (~ctrl_ff[1] & b_gpio);
  wire [7:0] b_en   = dir_ff[1] | oe_term_b;

  // Port C pin function, byte enable pin and test takeover
  wire [7:0] c_cell = two_to_c ? csel_ff[2] : 8'h00;
  wire [7:0] c_gpio = (c_cell & output_cell_group_two) | (~c_cell & dout_ff[2]);
  wire [7:0] c_dbe  = {dbe_en, 7'h00};
  wire [7:0] c_val  = jtag_enable ? jtag_out : c_gpio;
  wire [7:0] c_en   = jtag_enable ? jtag_oe :
                      ((dir_ff[2] | oe_term_c) & ~c_dbe);
  assign jtag_in = sc;
  assign data_byte_enable_input = dbe_en & sc[7];

  // Port D: external selects, dedicated chip select input
  wire [2:0] ecs_val = ~(select_terms ^ ecs_pol_ff);
  wire [2:0] d_sel   = csel_ff[3][2:0];
  wire [2:0] d_val   = (d_sel & ecs_val) | (~d_sel & dout_ff[3][2:0]);
  wire [2:0] d_en    = (dir_ff[3][2:0] | oe_term_d) & ~{csi_en, 2'h0};

  // Drive selection
  wire [7:0] a_od = {drv_ff[0][`CIPL_DRV_OD_HI:`CIPL_DRV_OD_LO], 4'h0};
  wire [7:0] b_od = {drv_ff[1][`CIPL_DRV_OD_HI:`CIPL_DRV_OD_LO], 4'h0};
  wire [7:0] c_od = jtag_enable ? 8'h00 : drv_ff[2];
  assign pa_fast_slew = drv_ff[0][`CIPL_DRV_SLEW_HI:`CIPL_DRV_SLEW_LO];
  assign pb_fast_slew = drv_ff[1][`CIPL_DRV_SLEW_HI:`CIPL_DRV_SLEW_LO];
  assign pd_fast_slew = drv_ff[3][`CIPL_D_PINS-1:0];

  cipl_pad #(.WIDTH(8)) u_pad_a (
    .value(a_val), .enable(a_en), .od_sel(a_od), .pin_out(pa_out), .pin_oe(pa_oe));
  cipl_pad #(.WIDTH(8)) u_pad_b (
    .value(b_val), .enable(b_en), .od_sel(b_od), .pin_out(pb_out), .pin_oe(pb_oe));
  cipl_pad #(.WIDTH(8)) u_pad_c (
    .value(c_val), .enable(c_en), .od_sel(c_od), .pin_out(pc_out), .pin_oe(pc_oe));
  cipl_pad #(.WIDTH(3)) u_pad_d (
    .value(d_val), .enable(d_en), .od_sel(3'h0), .pin_out(pd_out), .pin_oe(pd_oe));

  // Read multiplexer
  always @* begin
    nxt_rdata = `CIPL_UNMAPPED;
    case (rtype)
      `CIPL_TYPE_PIN_INPUT_SAMPLE: begin
        case (rport)
          `CIPL_PORT_A: nxt_rdata = sa;
          `CIPL_PORT_B: nxt_rdata = sb;
          `CIPL_PORT_C: nxt_rdata = sc;
          default:      nxt_rdata = {5'h00, sd};
        endcase
      end
      `CIPL_TYPE_MODE_CONTROL:
        nxt_rdata = rport[1] ? `CIPL_UNMAPPED : ctrl_ff[rport[0]];
      `CIPL_TYPE_PIN_OUTPUT_LATCH: nxt_rdata = dout_ff[rport];
      `CIPL_TYPE_DIRECTION:        nxt_rdata = dir_ff[rport];
      `CIPL_TYPE_PAD_DRIVE_SELECT: nxt_rdata = drv_ff[rport];
      `CIPL_TYPE_LOGIC_CELL_OUTPUT:
        nxt_rdata = (rport == `CIPL_PORT_A) ? output_cell_group_one :
                    (rport != `CIPL_PORT_D) ? output_cell_group_two : `CIPL_UNMAPPED;
      `CIPL_TYPE_LOGIC_CELL_BLOCK:
        nxt_rdata = (rport == `CIPL_PORT_A) ? blk_one_ff :
                    (rport != `CIPL_PORT_D) ? blk_two_ff : `CIPL_UNMAPPED;
      `CIPL_TYPE_INPUT_LATCH_CELL: begin
        case (rport)
          `CIPL_PORT_A: nxt_rdata = ilc_a_ff;
          `CIPL_PORT_B: nxt_rdata = ilc_b_ff;
          `CIPL_PORT_C: nxt_rdata = ilc_c_ff;
          default:      nxt_rdata = `CIPL_UNMAPPED;
        endcase
      end
      `CIPL_TYPE_DRIVER_ENABLE_VIEW: begin
        case (rport)
          `CIPL_PORT_A: nxt_rdata = a_en;
          `CIPL_PORT_B: nxt_rdata = b_en;
          `CIPL_PORT_C: nxt_rdata = c_en;
          default:      nxt_rdata = `CIPL_UNMAPPED;
        endcase
      end
      `CIPL_TYPE_CELL_SELECT: nxt_rdata = csel_ff[rport];
      `CIPL_TYPE_PORT_FUNCTION:
        nxt_rdata = (rport == `CIPL_PORT_A) ? func_ff :
                    (rport == `CIPL_PORT_B) ? {5'h00, ecs_pol_ff} : `CIPL_UNMAPPED;
      default: nxt_rdata = `CIPL_UNMAPPED;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mcu_rdata <= 8'h00;
    end else if (mcu_rd) begin
      mcu_rdata <= rd_en ? nxt_rdata : `CIPL_UNMAPPED;
    end
  end

endmodule // cipl_port

`default_nettype wire

// File: rtl/cipl_sync.v
`timescale 1ns/1ps
`default_nettype none

module cipl_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock,   // System clock
  input  wire             rst,     // Async reset, high
  input  wire [WIDTH-1:0] async_in, // Signal from outside the domain
  output wire [WIDTH-1:0] sync_out  // Synchronised level
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // cipl_sync

`default_nettype wire
